// ### bench/pro_mem_model.sv
// display memory model answering destination reads after a random delay
`timescale 1ns/1ps
`default_nettype none
module pro_mem_model
    import pro_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic mem_rd,
    input wire logic [PRO_WORD-1:0] mem_rd_addr,
    output logic mem_rd_valid,
    output logic [PRO_PLANES-1:0][PRO_WORD-1:0] mem_rd_data
);
    logic pend;
    logic [2:0] wait_cnt;
    logic [PRO_WORD-1:0] a;
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pend <= 1'b0;
            wait_cnt <= 3'h0;
            a <= 16'h0000;
            mem_rd_valid <= 1'b0;
            mem_rd_data <= '0;
        end
        else
        begin
            mem_rd_valid <= 1'b0;
            mem_rd_data <= ~mem_rd_data;
            if (mem_rd)
            begin
                pend <= 1'b1;
                a <= mem_rd_addr;
                wait_cnt <= 3'($urandom_range(3, 0));
            end
            else if (pend && wait_cnt != 3'h0)
                wait_cnt <= wait_cnt - 3'h1;
            else if (pend)
            begin
                // destination word of each plane for the read-modify-write
                pend <= 1'b0;
                mem_rd_valid <= 1'b1;
                for (int p = 0; p < PRO_PLANES; p++)
                    mem_rd_data[p] <= a ^ {4{p[3:0]}} ^ 16'ha5c3;
            end
        end
    end
endmodule // pro_mem_model
`default_nettype wire

// ### bench/pro_raster_op_tb_top.sv
// self-checking testbench for the plane raster operation unit
`timescale 1ns/1ps
`default_nettype none
module pro_raster_op_tb_top
    import pro_pkg::*;
;
    typedef struct packed {logic skip; pro_mem_t m;} pro_exp_t;
    logic core_clk = 0, sys_rst = 1, set_color = 0, set_search = 0, set_active = 0, set_brush = 0;
    logic brush_en_value = 0, req_valid = 0, req_ready, mem_rd, mem_rd_valid, mem_wr, brush_pattern, skipped;
    logic [3:0] plane_value = 0, color_bits, search_bits, active_bits, colr = 0, srch = 0, act = 4'hf;
    logic brush_on = 0;
    pro_req_t req = '0;
    logic [15:0] mem_rd_addr;
    logic [3:0][15:0] mem_rd_data;
    pro_mem_t mem_wr_bus;
    int n_errors = 0, samples_checked = 0, cycles = 0;
    pro_exp_t exp_q[$];
    pro_exp_t e;
    pro_raster_op dut (.core_clk, .sys_rst, .set_color, .set_search, .set_active, .set_brush, .plane_value,
        .brush_en_value, .req_valid, .req, .req_ready, .mem_rd, .mem_rd_addr, .mem_rd_valid, .mem_rd_data,
        .mem_wr, .mem_wr_bus, .color_bits, .search_bits, .active_bits, .brush_pattern, .skipped);
    pro_mem_model mem (.core_clk, .sys_rst, .mem_rd, .mem_rd_addr, .mem_rd_valid, .mem_rd_data);
    initial forever #2.5 core_clk = ~core_clk;
    task automatic cmp_bits(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected bits at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_wr(input pro_mem_t got, input pro_mem_t exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected write at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (exp_q.size() != 0)
            n_errors++;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    function automatic pro_mem_t expect_wr(input pro_req_t r);
        logic [15:0] s, d;
        pro_mem_t m;
        m.addr = r.addr;
        m.plane_en = act;
        for (int p = 0; p < 4; p++)
        begin
            s = r.src[p] ^ {16{r.source_invert}};
            d = r.addr ^ {4{p[3:0]}} ^ 16'ha5c3;
            case (r.raster_op_code)
                PRO_OP_LSET: m.data[p] = s;
                PRO_OP_LOR: m.data[p] = s | d;
                PRO_OP_LAND: m.data[p] = s & d;
                PRO_OP_LXOR: m.data[p] = s ^ d;
                PRO_OP_LZERO: m.data[p] = ~s & d;
                PRO_OP_GSET: m.data[p] = colr[p] ? s | d : ~s & d;
                PRO_OP_GOR: m.data[p] = colr[p] ? s | d : d;
                default: m.data[p] = colr[p] ? s ^ d : d;
            endcase
        end
        return m;
    endfunction
    task automatic send(input int op, input int kind);
        pro_req_t r;
        r = {3'(op), 3'(kind), 1'($urandom), 16'($urandom), $urandom, $urandom};
        exp_q.push_back({kind > 2 && !brush_on, expect_wr(r)});
        req_valid <= 1'b1;
        req <= r;
        do @(posedge core_clk); while (req_ready !== 1'b1);
    endtask
    task automatic finish_test(input string name);
        req_valid <= 1'b0;
        for (int i = 0; i < 60 && exp_q.size() != 0; i++)
            @(posedge core_clk);
        $display("test %s done", name);
    endtask
    task automatic setr(input int which, input logic [3:0] v);
        plane_value <= v;
        brush_en_value <= v[0];
        {set_brush, set_active, set_search, set_color} <= 4'(1 << which);
        @(posedge core_clk);
        {set_brush, set_active, set_search, set_color} <= 4'h0;
        case (which)
            0: colr = v;
            1: srch = v;
            2: act = v;
            default: brush_on = v[0];
        endcase
        @(negedge core_clk);
        cmp_bits({3'h0, brush_pattern, active_bits, search_bits, color_bits}, {3'h0, brush_on, act, srch, colr});
        @(posedge core_clk);
    endtask
    always @(negedge core_clk)
    begin
        if (!sys_rst && (mem_wr === 1'b1 || skipped === 1'b1))
        begin
            if (exp_q.size() == 0)
            begin
                n_errors++;
                $display("unexpected result at %0t got %h exp %h", $time, {skipped, mem_wr}, 2'h0);
            end
            else
            begin
                e = exp_q.pop_front();
                cmp_bits(16'(skipped), 16'(e.skip));
                if (mem_wr === 1'b1)
                    cmp_wr(mem_wr_bus, e.m);
            end
        end
    end
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial
    begin
        void'($urandom(34));
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        cmp_bits(16'({req_ready, brush_pattern, active_bits, search_bits, color_bits}),
            16'({1'b1, PRO_BRUSH_RST, PRO_ACTIVE_RST, PRO_SEARCH_RST, PRO_COLOR_RST}));
        @(posedge core_clk);
        finish_test("reset");
        setr(1, 4'($urandom));
        setr(3, 4'h1);
        for (int c = 0; c < 4; c++)
        begin
            setr(0, c[0] ? 4'h5 : 4'ha);
            setr(2, 4'($urandom));
            for (int op = 0; op < 8; op++)
                send(op, $urandom_range(6, 0));
            for (int k = 0; k < 4; k++)
                send(0, k % 3);
            finish_test("op sweep");
        end
        setr(3, 4'h0);
        setr(2, 4'h6);
        for (int k = 0; k < 7; k++)
            send($urandom_range(7, 0), k);
        finish_test("brush off");
        tally_and_finish();
    end
endmodule // pro_raster_op_tb_top
`default_nettype wire

// ### rtl/pro_bit_op.sv
// one-plane combining logic for one word
`timescale 1ns/1ps
`default_nettype none
module pro_bit_op
    import pro_pkg::*;
#(
    parameter int WIDTH = PRO_WORD
)
(
    input wire pro_op_t op,
    input wire logic color,
    input wire logic [WIDTH-1:0] s,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] r
);
    wire [WIDTH-1:0] s_or_d = s | d;
    wire [WIDTH-1:0] s_and_d = s & d;
    wire [WIDTH-1:0] s_xor_d = s ^ d;
    wire [WIDTH-1:0] ns_and_d = ~s & d;

    // bitwise only, so no neighbour coupling [RL2]
    assign r = (op == PRO_OP_LSET) ? s : // [RL6]
               (op == PRO_OP_LOR) ? s_or_d : // [RL7]
               (op == PRO_OP_LAND) ? s_and_d : // [RL8]
               (op == PRO_OP_LXOR) ? s_xor_d : // [RL9]
               (op == PRO_OP_LZERO) ? ns_and_d : // [RL10]
               (op == PRO_OP_GSET) ? (color ? s_or_d : ns_and_d) : // [RL11]
               (op == PRO_OP_GOR) ? (color ? s_or_d : d) : // [RL12]
               (color ? s_xor_d : d); // [RL13]
endmodule // pro_bit_op
`default_nettype wire

// ### rtl/pro_pkg.sv
// constants, types and rule summary for the plane raster operation unit
// Summary of operation
// RL1 - a 3-bit raster_op_code in each instruction selects one of eight operations
// RL2 - every pixel in every plane is combined on its own, with no interaction
// RL3 - one colour bit and one search-colour bit per plane, each set by instruction
// RL4 - result formed from source, destination and plane colour, after optional source invert
// RL5 - copy, string, transform carry a source; drawing uses brush_pattern when enabled
// RL6 - code 000 replaces destination with source, colour ignored
// RL7 - code 001 writes source OR destination, colour ignored
// RL8 - code 010 writes source AND destination, colour ignored
// RL9 - code 011 writes source XOR destination, colour ignored
// RL10 - code 100 writes destination AND NOT source, colour ignored
// RL11 - code 101: colour 1 gives S OR D, colour 0 gives NOT S AND D
// RL12 - code 110: colour 1 gives S OR D, colour 0 keeps destination
// RL13 - code 111: colour 1 gives S XOR D, colour 0 keeps destination
// RL14 - per-plane activity bits suppress writes into deselected planes
// RL15 - source invert complements source data before the combining operation
// RL16 - every code except replace reads destination, combines, writes back
package pro_pkg;

    localparam int PRO_PLANES = 4;
    localparam int PRO_WORD = 16;

    typedef enum logic [2:0] {
        PRO_OP_LSET = 3'h0,
        PRO_OP_LOR = 3'h1,
        PRO_OP_LAND = 3'h2,
        PRO_OP_LXOR = 3'h3,
        PRO_OP_LZERO = 3'h4,
        PRO_OP_GSET = 3'h5,
        PRO_OP_GOR = 3'h6,
        PRO_OP_GXOR = 3'h7
    } pro_op_t;

    typedef enum logic [2:0] {
        PRO_SRC_COPY = 3'h0,
        PRO_SRC_STRING = 3'h1,
        PRO_SRC_TRANSFORM = 3'h2,
        PRO_SRC_POINT = 3'h3,
        PRO_SRC_LINE = 3'h4,
        PRO_SRC_ARC = 3'h5,
        PRO_SRC_CIRCLE = 3'h6
    } pro_src_t;

    // one drawing operand from the engine
    typedef struct packed {
        pro_op_t raster_op_code;
        pro_src_t kind;
        logic source_invert;
        logic [PRO_WORD-1:0] addr;
        logic [PRO_PLANES-1:0][PRO_WORD-1:0] src;
    } pro_req_t;

    // one display memory access
    typedef struct packed {
        logic [PRO_WORD-1:0] addr;
        logic [PRO_PLANES-1:0] plane_en;
        logic [PRO_PLANES-1:0][PRO_WORD-1:0] data;
    } pro_mem_t;

    localparam logic [PRO_PLANES-1:0] PRO_COLOR_RST = 4'h0;
    localparam logic [PRO_PLANES-1:0] PRO_SEARCH_RST = 4'h0;
    localparam logic [PRO_PLANES-1:0] PRO_ACTIVE_RST = 4'hf;
    localparam logic PRO_BRUSH_RST = 1'b0;

endpackage

// ### rtl/pro_raster_op.sv
// plane raster operation unit with read-modify-write sequencing
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module pro_raster_op
    import pro_pkg::*;
#(
    parameter int PLANES = PRO_PLANES,
    parameter int WIDTH = PRO_WORD
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic set_color,
    input wire logic set_search,
    input wire logic set_active,
    input wire logic set_brush,
    input wire logic [PLANES-1:0] plane_value,
    input wire logic brush_en_value,
    input wire logic req_valid,
    input wire pro_req_t req,
    output logic req_ready,
    output logic mem_rd,
    output logic [WIDTH-1:0] mem_rd_addr,
    input wire logic mem_rd_valid,
    input wire logic [PLANES-1:0][WIDTH-1:0] mem_rd_data,
    output logic mem_wr,
    output pro_mem_t mem_wr_bus,
    output logic [PLANES-1:0] color_bits,
    output logic [PLANES-1:0] search_bits,
    output logic [PLANES-1:0] active_bits,
    output logic brush_pattern,
    output logic skipped
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_READ = 3'h2,
        ST_WAIT = 3'h4
    } pro_state_t;

    pro_state_t state;
    pro_state_t next_state;
    pro_req_t held;

    // drawing kinds only have a source when the brush is enabled [RL5]
    function automatic logic has_source(input pro_src_t k, input logic br);
        has_source = (k == PRO_SRC_COPY) || (k == PRO_SRC_STRING) || (k == PRO_SRC_TRANSFORM) || br;
    endfunction

    wire take = req_valid && req_ready;
    wire take_ok = take && has_source(req.kind, brush_pattern);
    wire take_skip = take && !has_source(req.kind, brush_pattern);
    wire direct = take_ok && (req.raster_op_code == PRO_OP_LSET); // [RL16]
    wire need_rmw = take_ok && (req.raster_op_code != PRO_OP_LSET); // [RL16]
    wire write_back = (state == ST_WAIT) && mem_rd_valid; // [RL16]

    logic [PLANES-1:0][WIDTH-1:0] src_eff;
    logic [PLANES-1:0][WIDTH-1:0] result;

    genvar p;
    generate
        for (p = 0; p < PLANES; p++)
        begin : g_plane
            // invert applies before combining [RL15] [RL4]
            assign src_eff[p] = held.source_invert ? ~held.src[p] : held.src[p];
            pro_bit_op #(.WIDTH(WIDTH)) u_op (
                .op(held.raster_op_code), // [RL1]
                .color(color_bits[p]), // [RL4]
                .s(src_eff[p]),
                .d(mem_rd_data[p]),
                .r(result[p])
            );
        end
    endgenerate

    logic [PLANES-1:0][WIDTH-1:0] direct_data;
    generate
        for (p = 0; p < PLANES; p++)
        begin : g_direct
            assign direct_data[p] = req.source_invert ? ~req.src[p] : req.src[p]; // [RL15] [RL6]
        end
    endgenerate

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE: if (need_rmw) next_state = ST_READ;
            ST_READ: next_state = ST_WAIT;
            ST_WAIT: if (mem_rd_valid) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    wire next_ready = (next_state == ST_IDLE);

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            color_bits <= PRO_COLOR_RST;
            search_bits <= PRO_SEARCH_RST;
            active_bits <= PRO_ACTIVE_RST;
            brush_pattern <= PRO_BRUSH_RST;
        end
        else
        begin
            if (set_color) color_bits <= plane_value; // [RL3]
            if (set_search) search_bits <= plane_value; // [RL3]
            if (set_active) active_bits <= plane_value; // [RL14]
            if (set_brush) brush_pattern <= brush_en_value; // [RL5]
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= ST_IDLE;
            req_ready <= 1'b1;
            held <= '0;
            mem_rd <= 1'b0;
            mem_rd_addr <= '0;
            mem_wr <= 1'b0;
            mem_wr_bus <= '0;
            skipped <= 1'b0;
        end
        else
        begin
            state <= next_state;
            req_ready <= next_ready;
            skipped <= take_skip;
            mem_rd <= need_rmw; // [RL16]
            if (take) held <= req;
            if (take) mem_rd_addr <= req.addr;
            mem_wr <= direct || write_back; // [RL16]
            if (direct)
            begin
                mem_wr_bus <= '{addr: req.addr, plane_en: active_bits, data: direct_data}; // [RL14]
            end
            else if (write_back)
            begin
                mem_wr_bus <= '{addr: held.addr, plane_en: active_bits, data: result}; // [RL14]
            end
        end
    end

    // checks
    sequence rmw_taken;
        req_valid && req_ready && has_source(req.kind, brush_pattern) && req.raster_op_code != PRO_OP_LSET;
    endsequence

    rmw_read_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL16]
        rmw_taken |=> mem_rd && !req_ready) else $error("rmw did not start read");
    direct_write_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL6]
        (req_valid && req_ready && has_source(req.kind, brush_pattern) && req.raster_op_code == PRO_OP_LSET)
        |=> mem_wr && !mem_rd && mem_wr_bus.data == $past(direct_data)) else $error("replace not direct");
    wb_after_read_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL16]
        (state == ST_WAIT && mem_rd_valid) |=> mem_wr && mem_wr_bus.data == $past(result))
        else $error("write back missing");
    plane_mask_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL14]
        $rose(mem_wr) |-> mem_wr_bus.plane_en == $past(active_bits)) else $error("plane mask wrong");
    color_load_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL3]
        set_color |=> color_bits == $past(plane_value)) else $error("colour not loaded");
    skip_nosrc_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL5]
        (req_valid && req_ready && !has_source(req.kind, brush_pattern)) |=> skipped && !mem_rd && !mem_wr)
        else $error("sourceless request used");
    gxor_keep_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL13]
        (held.raster_op_code == PRO_OP_GXOR && !color_bits[0]) |-> result[0] == mem_rd_data[0])
        else $error("graphical xor changed plane");
    lzero_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL10]
        (held.raster_op_code == PRO_OP_LZERO) |-> result[0] == (~src_eff[0] & mem_rd_data[0]))
        else $error("zero op wrong");
    gset_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL11]
        (held.raster_op_code == PRO_OP_GSET && color_bits[0]) |-> result[0] == (src_eff[0] | mem_rd_data[0]))
        else $error("graphical set wrong");
    invert_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL15]
        held.source_invert |-> src_eff[0] == ~held.src[0]) else $error("invert missing");
    wait_bound_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL16]
        (state == ST_READ) |=> state == ST_WAIT) else $error("read state stuck");

    // state loads and handshake checks
    search_load_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL3]
        set_search |=> search_bits == $past(plane_value)) else $error("search colour not loaded");
    active_load_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL14]
        set_active |=> active_bits == $past(plane_value)) else $error("activity bits not loaded");
    brush_load_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL5]
        set_brush |=> brush_pattern == $past(brush_en_value)) else $error("brush enable not loaded");
    busy_refuse_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL16]
        (state != ST_IDLE) |-> !req_ready) else $error("request accepted while busy");
    rd_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL16]
        mem_rd |=> !mem_rd) else $error("read strobe too long");
    rmw_addr_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL16]
        rmw_taken |=> mem_rd_addr == $past(req.addr)) else $error("read address wrong");
    addr_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL16]
        !take |=> $stable(mem_rd_addr)) else $error("read address moved");
    wb_addr_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL14]
        write_back |=> mem_wr_bus.addr == $past(held.addr) && mem_wr_bus.plane_en == $past(active_bits))
        else $error("write-back address or mask wrong");
    direct_addr_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL14]
        direct |=> mem_wr_bus.addr == $past(req.addr) && mem_wr_bus.plane_en == $past(active_bits))
        else $error("replace address or mask wrong");
    wr_cause_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL16]
        (!direct && !write_back) |=> !mem_wr) else $error("write without cause");
    bus_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL16]
        (!direct && !write_back) |=> mem_wr_bus == $past(mem_wr_bus))
        else $error("write bus moved");
    ready_back_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL16]
        write_back |=> req_ready && mem_wr) else $error("not idle after write-back");
    src_no_skip_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL5]
        take_ok |=> !skipped) else $error("sourced request dropped");

    // reference combining table for the checks, bit by bit [RL1]
    function automatic logic [WIDTH-1:0] ref_combine(
        input pro_op_t op,
        input logic c,
        input logic [WIDTH-1:0] s,
        input logic [WIDTH-1:0] d
    );
        logic [WIDTH-1:0] r;
        r = d;
        for (int i = 0; i < WIDTH; i++)
        begin
            case (op)
                PRO_OP_LSET: r[i] = s[i];
                PRO_OP_LOR: r[i] = s[i] | d[i];
                PRO_OP_LAND: r[i] = s[i] & d[i];
                PRO_OP_LXOR: r[i] = s[i] ^ d[i];
                PRO_OP_LZERO: r[i] = s[i] ? 1'b0 : d[i];
                PRO_OP_GSET: r[i] = s[i] ? c : d[i];
                PRO_OP_GOR: r[i] = (s[i] && c) ? 1'b1 : d[i];
                default: r[i] = (s[i] && c) ? !d[i] : d[i];
            endcase
        end
        return r;
    endfunction

    // every plane checked on every write [RL2]
    generate
        for (p = 0; p < PLANES; p++)
        begin : g_check
            wb_plane_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL2]
                write_back |=> mem_wr_bus.data[p] == ref_combine($past(held.raster_op_code),
                    $past(color_bits[p]), $past(src_eff[p]), $past(mem_rd_data[p])))
                else $error("write-back plane wrong");
            result_plane_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL4]
                write_back |-> result[p] == ref_combine(held.raster_op_code, color_bits[p], src_eff[p],
                    mem_rd_data[p]))
                else $error("combined plane wrong");
            invert_plane_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL15]
                held.source_invert |-> src_eff[p] == ~held.src[p]) else $error("plane invert missing");
            plain_plane_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL15]
                !held.source_invert |-> src_eff[p] == held.src[p]) else $error("plane inverted unasked");
            lset_plane_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL6]
                direct |=> mem_wr_bus.data[p] == ($past(req.src[p]) ^ {WIDTH{$past(req.source_invert)}}))
                else $error("replace wrong in plane");
            lor_plane_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL7]
                (write_back && held.raster_op_code == PRO_OP_LOR)
                |=> mem_wr_bus.data[p] == ($past(src_eff[p]) | $past(mem_rd_data[p])))
                else $error("logical or wrong");
            land_plane_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL8]
                (write_back && held.raster_op_code == PRO_OP_LAND)
                |=> mem_wr_bus.data[p] == ($past(src_eff[p]) & $past(mem_rd_data[p])))
                else $error("logical and wrong");
            lxor_plane_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL9]
                (write_back && held.raster_op_code == PRO_OP_LXOR)
                |=> mem_wr_bus.data[p] == ($past(src_eff[p]) ^ $past(mem_rd_data[p])))
                else $error("logical xor wrong");
            lzero_plane_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL10]
                (write_back && held.raster_op_code == PRO_OP_LZERO)
                |=> mem_wr_bus.data[p] == (~$past(src_eff[p]) & $past(mem_rd_data[p])))
                else $error("logical zero wrong");
            gset_one_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL11]
                (write_back && held.raster_op_code == PRO_OP_GSET && color_bits[p])
                |=> mem_wr_bus.data[p] == ($past(src_eff[p]) | $past(mem_rd_data[p])))
                else $error("graphical set colour one wrong");
            gset_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL11]
                (write_back && held.raster_op_code == PRO_OP_GSET && !color_bits[p])
                |=> mem_wr_bus.data[p] == (~$past(src_eff[p]) & $past(mem_rd_data[p])))
                else $error("graphical set colour zero wrong");
            gor_one_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL12]
                (write_back && held.raster_op_code == PRO_OP_GOR && color_bits[p])
                |=> mem_wr_bus.data[p] == ($past(src_eff[p]) | $past(mem_rd_data[p])))
                else $error("graphical or colour one wrong");
            gor_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL12]
                (write_back && held.raster_op_code == PRO_OP_GOR && !color_bits[p])
                |=> mem_wr_bus.data[p] == $past(mem_rd_data[p]))
                else $error("graphical or colour zero wrong");
            gxor_one_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL13]
                (write_back && held.raster_op_code == PRO_OP_GXOR && color_bits[p])
                |=> mem_wr_bus.data[p] == ($past(src_eff[p]) ^ $past(mem_rd_data[p])))
                else $error("graphical xor colour one wrong");
            gxor_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL13]
                (write_back && held.raster_op_code == PRO_OP_GXOR && !color_bits[p])
                |=> mem_wr_bus.data[p] == $past(mem_rd_data[p]))
                else $error("graphical xor colour zero wrong");
        end
    endgenerate

    rmw_seen_c: cover property (@(posedge core_clk) disable iff (sys_rst) rmw_taken ##[2:8] mem_wr);
    direct_seen_c: cover property (@(posedge core_clk) disable iff (sys_rst) direct ##1 mem_wr);
    skip_seen_c: cover property (@(posedge core_clk) disable iff (sys_rst) skipped);
    invert_seen_c: cover property (@(posedge core_clk) disable iff (sys_rst) write_back && held.source_invert);
    gxor_seen_c: cover property (@(posedge core_clk) disable iff (sys_rst)
        write_back && held.raster_op_code == PRO_OP_GXOR && color_bits[0]);
endmodule // pro_raster_op
`default_nettype wire
